/* rtl/flush_fifo.v */
// FIFO with push and pop sides, synchronous flush on either side,
// direct asynchronous clear of the pointers, AXI4-Lite registers and irq.
// Assumes one clock; push_tick and pop_tick are one-cycle enables marking
// the rising edges of the two side rates, which need not be related.
//
// Behaviour
// - Push and pop sides each have a flush input sampled on own tick.
// - A flush from either side is carried to the other side; whole FIFO empties.
// - After push flush, almost-full and push level invalid until both sides done.
// - Pop-side flush routine starts on the pop tick following a push flush.
// - Push flush: levels update after two pop ticks, almost-empty marks completion.
// - Push level shown valid at the next push tick after completion.
// - Pop flush: levels update after two push ticks, almost-empty marks completion.
// - Pop level shown valid at the next pop tick after completion.
// - Flush latency may grow one tick in either domain.
// - Asynchronous clear resets both pointers directly, no filtering.
// - Push level code: full is 0000, empty 0001, graded room otherwise.
// - Almost-empty set when exactly one entry is held.
// - Asynchronous clear polarity is selectable, inverted or not.
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "flush_fifo_defs.vh"
module flush_fifo #(
    parameter AW = 9,
    parameter DW = 18
) (
    // Clock and reset
    input  wire          aclk,
    input  wire          aresetn,
    // AXI4-Lite slave
    input  wire [7:0]    s_axi_awaddr,
    input  wire          s_axi_awvalid,
    output reg           s_axi_awready,
    input  wire [31:0]   s_axi_wdata,
    input  wire [3:0]    s_axi_wstrb,
    input  wire          s_axi_wvalid,
    output reg           s_axi_wready,
    output reg  [1:0]    s_axi_bresp,
    output reg           s_axi_bvalid,
    input  wire          s_axi_bready,
    input  wire [7:0]    s_axi_araddr,
    input  wire          s_axi_arvalid,
    output reg           s_axi_arready,
    output reg  [31:0]   s_axi_rdata,
    output reg  [1:0]    s_axi_rresp,
    output reg           s_axi_rvalid,
    input  wire          s_axi_rready,
    // Push side
    input  wire          push_tick,
    input  wire          push,
    input  wire          push_flush,
    input  wire [DW-1:0] din,
    // Pop side
    input  wire          pop_tick,
    input  wire          pop,
    input  wire          pop_flush,
    output reg  [DW-1:0] dout,
    // Status flags
    output reg           almost_full,
    output reg           almost_empty,
    output reg  [3:0]    push_level,
    output reg  [3:0]    pop_level,
    output reg           push_level_ok,
    output reg           pop_level_ok,
    // Asynchronous clear and interrupt
    input  wire          async_clr,
    output reg           irq
);
    localparam [AW:0] DEPTH_V = {1'b1, {AW{1'b0}}};
    localparam [2:0] ST_IDLE    = 3'd0;
    localparam [2:0] ST_PF_POP  = 3'd1;
    localparam [2:0] ST_PF_PUSH = 3'd2;
    localparam [2:0] ST_QF_PUSH = 3'd3;
    localparam [2:0] ST_QF_POP  = 3'd4;
    reg  [DW-1:0]        mem [0:(1<<AW)-1];
    reg  [AW:0]          wptr_r;
    reg  [AW:0]          rptr_r;
    reg  [2:0]           state_r;
    reg  [1:0]           cnt_r;
    reg                  clr_inv_r;
    reg  [`INT_W-1:0]    int_stat_r;
    reg  [`INT_W-1:0]    int_mask_r;
    reg                  aw_got_r;
    reg                  w_got_r;
    reg  [7:0]           awaddr_q_r;
    reg  [31:0]          wdata_q_r;
    reg  [3:0]           wstrb_q_r;
    reg  [31:0]          rd_nxt;
    reg                  rd_hit;
    wire [AW:0]          fill = wptr_r - rptr_r;
    wire [AW:0]          room = DEPTH_V - fill;
    wire                 full = (fill == DEPTH_V);
    wire                 empty = (fill == {(AW+1){1'b0}});
    wire                 idle = (state_r == ST_IDLE);
    wire                 do_push = push_tick & push & ~full & idle & ~push_flush;
    wire                 do_pop = pop_tick & pop & ~empty & idle & ~pop_flush;
    wire                 last_tick = (cnt_r == `FLUSH_TICKS - 2'd1);
    // Clear goes straight to the pointer flops
    wire                 clr_act = async_clr ^ clr_inv_r;
    wire                 flush_clr = (state_r == ST_PF_POP && pop_tick && last_tick) ||
                                     (state_r == ST_QF_PUSH && push_tick && last_tick);
    wire                 wr_fire = aw_got_r & w_got_r & ~s_axi_bvalid;
    wire [7:0]           wr_ofs = {awaddr_q_r[7:2], 2'b00};
    wire [7:0]           rd_ofs = {s_axi_araddr[7:2], 2'b00};
    wire [`INT_W-1:0]    ev;
    assign ev[`INT_PUSH_DONE] = (state_r == ST_PF_PUSH) & push_tick;
    assign ev[`INT_POP_DONE]  = (state_r == ST_QF_POP) & pop_tick;
    assign ev[`INT_OVERFLOW]  = push_tick & push & full & idle;
    assign ev[`INT_UNDERFLOW] = pop_tick & pop & empty & idle;
    function [3:0] push_code;
        input [AW:0] f;
        input [AW:0] r;
        begin
            if (f == DEPTH_V)           push_code = `PUSH_LVL_FULL;
            else if (f == 0)            push_code = `PUSH_LVL_EMPTY;
            else if (r > (DEPTH_V >> 1)) push_code = 4'h2;
            else if (r > (DEPTH_V >> 2)) push_code = 4'h3;
            else if (r >= 64)           push_code = 4'h4;
            else if (r >= 32)           push_code = 4'hA;
            else if (r >= 16)           push_code = 4'hB;
            else if (r >= 8)            push_code = 4'hC;
            else if (r >= 4)            push_code = 4'hD;
            else if (r >= 2)            push_code = 4'hE;
            else                        push_code = 4'hF;
        end
    endfunction
    function [3:0] pop_code;
        input [AW:0] f;
        begin
            if (f == 0)                       pop_code = `POP_LVL_EMPTY;
            else if (f == 1)                  pop_code = `POP_LVL_ONE;
            else if (f == DEPTH_V)            pop_code = `POP_LVL_FULL;
            else if (f >= (DEPTH_V >> 1))     pop_code = 4'hE;
            else if (f >= (DEPTH_V >> 2))     pop_code = 4'hD;
            else if (f >= 64)                 pop_code = 4'h8;
            else if (f >= 32)                 pop_code = 4'h6;
            else if (f >= 16)                 pop_code = 4'h5;
            else if (f >= 8)                  pop_code = 4'h4;
            else if (f >= 4)                  pop_code = 4'h3;
            else                              pop_code = 4'h2;
        end
    endfunction
    // Pointers: asynchronous clear, synchronous reset and flush
    always @(posedge aclk or posedge clr_act) begin
        if (clr_act) begin
            wptr_r <= {(AW+1){1'b0}};
            rptr_r <= {(AW+1){1'b0}};
        end else if (!aresetn || flush_clr) begin
            wptr_r <= {(AW+1){1'b0}};
            rptr_r <= {(AW+1){1'b0}};
        end else begin
            if (do_push)
                wptr_r <= wptr_r + 1'b1;
            if (do_pop)
                rptr_r <= rptr_r + 1'b1;
        end
    end
    always @(posedge aclk) begin
        if (do_push)
            mem[wptr_r[AW-1:0]] <= din;
    end
    always @(posedge aclk) begin
        if (!aresetn)
            dout <= {DW{1'b0}};
        else if (do_pop)
            dout <= mem[rptr_r[AW-1:0]];
    end
    // Flush sequencer
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= ST_IDLE;
            cnt_r   <= 2'd0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    cnt_r <= 2'd0;
                    if (push_tick && push_flush)
                        state_r <= ST_PF_POP;
                    else if (pop_tick && pop_flush)
                        state_r <= ST_QF_PUSH;
                end
                ST_PF_POP: begin
                    // Counting starts at next pop tick
                    if (pop_tick) begin
                        cnt_r <= cnt_r + 2'd1;
                        if (last_tick)
                            state_r <= ST_PF_PUSH;
                    end
                end
                // Handback on the first tick, no slack tick added
                ST_PF_PUSH: if (push_tick)
                    state_r <= ST_IDLE;
                ST_QF_PUSH: begin
                    // Pop flush carried to push side
                    if (push_tick) begin
                        cnt_r <= cnt_r + 2'd1;
                        if (last_tick)
                            state_r <= ST_QF_POP;
                    end
                end
                ST_QF_POP: if (pop_tick)
                    state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end
    // Flags and level codes
    always @(posedge aclk) begin
        if (!aresetn) begin
            push_level    <= `PUSH_LVL_EMPTY;
            pop_level     <= `POP_LVL_EMPTY;
            almost_full   <= 1'b0;
            almost_empty  <= 1'b0;
            push_level_ok <= 1'b1;
            pop_level_ok  <= 1'b1;
        end else if (flush_clr) begin
            // Levels show empty, almost-empty marks completion
            push_level   <= `PUSH_LVL_EMPTY;
            pop_level    <= `POP_LVL_EMPTY;
            almost_full  <= 1'b0;
            almost_empty <= 1'b1;
        end else if (idle) begin
            // Push flags invalid from push flush
            if (push_tick && push_flush)
                push_level_ok <= 1'b0;
            // Pop flags invalid from pop flush
            else if (pop_tick && pop_flush)
                pop_level_ok <= 1'b0;
            if (push_tick) begin
                push_level  <= push_code(fill, room);
                almost_full <= (room == 1);
            end
            if (pop_tick) begin
                pop_level    <= pop_code(fill);
                almost_empty <= (fill == 1);
            end
        end else begin
            // Push side sees completion on its next tick
            if (state_r == ST_PF_PUSH && push_tick)
                push_level_ok <= 1'b1;
            // Pop side sees completion on its next tick
            if (state_r == ST_QF_POP && pop_tick)
                pop_level_ok <= 1'b1;
        end
    end
    // AXI write channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r      <= 1'b1;
                awaddr_q_r    <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r      <= 1'b1;
                wdata_q_r    <= s_axi_wdata;
                wstrb_q_r    <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_ofs > `REG_INT_MASK) ? `RESP_SLVERR : `RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end
    // Registers and interrupt; a new event wins over a clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            clr_inv_r  <= `CTRL_RST;
            int_mask_r <= `INT_MASK_RST;
            int_stat_r <= {`INT_W{1'b0}};
            irq        <= 1'b0;
        end else begin
            if (wr_fire && wstrb_q_r[0] && wr_ofs == `REG_CTRL)
                clr_inv_r <= wdata_q_r[`CTRL_CLR_INV];
            if (wr_fire && wstrb_q_r[0] && wr_ofs == `REG_INT_MASK)
                int_mask_r <= wdata_q_r[`INT_W-1:0];
            if (wr_fire && wstrb_q_r[0] && wr_ofs == `REG_INT_STAT)
                int_stat_r <= (int_stat_r & ~wdata_q_r[`INT_W-1:0]) | ev;
            else
                int_stat_r <= int_stat_r | ev;
            irq <= |(int_stat_r & int_mask_r);
        end
    end
    always @* begin
        rd_nxt = 32'h00000000;
        rd_hit = 1'b1;
        case (rd_ofs)
            `REG_CTRL:     rd_nxt[`CTRL_CLR_INV] = clr_inv_r;
            `REG_STATUS:   rd_nxt[16:0] = {pop_level_ok, push_level_ok, almost_empty,
                                           almost_full, pop_level, push_level, state_r, 2'b00};
            `REG_INT_STAT: rd_nxt[`INT_W-1:0] = int_stat_r;
            `REG_INT_MASK: rd_nxt[`INT_W-1:0] = int_mask_r;
            default:       rd_hit = 1'b0;
        endcase
    end
    // AXI read channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_nxt;
            s_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule // flush_fifo
`default_nettype wire

/* rtl/flush_fifo_defs.vh */
// Constants for the flush-controlled FIFO: register map, fields,
// reset values, level codes and flush timing.
// Included by the design file, the checker and the bench; definitions, no logic.
`ifndef FLUSH_FIFO_DEFS_VH
`define FLUSH_FIFO_DEFS_VH

// Register byte offsets on the AXI4-Lite bus
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_INT_STAT    8'h08
`define REG_INT_MASK    8'h0C

// Control fields and reset values
`define CTRL_CLR_INV    0
`define CTRL_RST        1'b0
`define INT_MASK_RST    4'h0

// Interrupt status fields
`define INT_PUSH_DONE   0
`define INT_POP_DONE    1
`define INT_OVERFLOW    2
`define INT_UNDERFLOW   3
`define INT_W           4

// Level codes
`define PUSH_LVL_FULL   4'h0
`define PUSH_LVL_EMPTY  4'h1
`define POP_LVL_EMPTY   4'h0
`define POP_LVL_ONE     4'h1
`define POP_LVL_FULL    4'hF

// Far-side ticks before the flush clears the pointers
`define FLUSH_TICKS     2'd2

// AXI responses
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

/* testbench/fabric_side.sv */
// Fabric-side model: tick enables for both sides and a filter on the clear.
// Assumes one bench clock; the two tick rates are unrelated divisions of it.
`timescale 1ns/1ps
`default_nettype none
module fabric_side #(
    parameter int PUSH_DIV = 3,
    parameter int POP_DIV  = 5
) (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Raw clear request
    input  wire logic clr_raw,
    // Towards the FIFO
    output var  logic push_tick,
    output var  logic pop_tick,
    output var  logic async_clr
);
    integer     push_cnt;
    integer     pop_cnt;
    logic [1:0] clr_sr;

    always @(posedge aclk) begin
        if (!aresetn) begin
            push_cnt <= 0;
            pop_cnt <= 0;
            push_tick <= 1'b0;
            pop_tick <= 1'b0;
            clr_sr <= 2'b00;
            async_clr <= 1'b0;
        end else begin
            push_cnt <= (push_cnt == PUSH_DIV - 1) ? 0 : push_cnt + 1;
            pop_cnt <= (pop_cnt == POP_DIV - 1) ? 0 : pop_cnt + 1;
            push_tick <= (push_cnt == 0);
            pop_tick <= (pop_cnt == 0);
            clr_sr <= {clr_sr[0], clr_raw};
            if (clr_sr[1] == clr_sr[0]) async_clr <= clr_sr[1];
        end
    end
endmodule // fabric_side
`default_nettype wire

/* testbench/flush_fifo_properties.sv */
// Checker: flush sequencing, level flags and AXI answer timing of flush_fifo.
// Assumes both tick enables keep running while a flush is pending.
`timescale 1ns/1ps
`default_nettype none
`include "flush_fifo_defs.vh"
module flush_fifo_properties (
    // Clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // AXI handshakes
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    // FIFO sides
    input wire logic       push_tick,
    input wire logic       push_flush,
    input wire logic       pop_tick,
    input wire logic       pop_flush,
    // Flags
    input wire logic       almost_full,
    input wire logic       almost_empty,
    input wire logic [3:0] push_level,
    input wire logic [3:0] pop_level,
    input wire logic       push_level_ok,
    input wire logic       pop_level_ok
);
    logic [1:0] pf_n;
    logic [1:0] qf_n;
    wire        idle_ok = push_level_ok && pop_level_ok;
    wire        take_p  = push_tick && push_flush && idle_ok;
    wire        take_q  = pop_tick && pop_flush && !(push_tick && push_flush) && idle_ok;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Far-side ticks seen since a flush was taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            pf_n <= 2'd3;
            qf_n <= 2'd3;
        end else begin
            if (take_p) pf_n <= 2'd0;
            else if (pf_n < 2'd2 && pop_tick) pf_n <= pf_n + 2'd1;
            if (take_q) qf_n <= 2'd0;
            else if (qf_n < 2'd2 && push_tick) qf_n <= qf_n + 2'd1;
        end
    end

    sequence s_push_last; pf_n == 2'd1 && pop_tick; endsequence
    sequence s_pop_last; qf_n == 2'd1 && push_tick; endsequence
    sequence s_emptied;
        almost_empty && !almost_full && push_level == `PUSH_LVL_EMPTY
            && pop_level == `POP_LVL_EMPTY;
    endsequence

    a_push_inval: assert property (take_p |=> !push_level_ok)
        else $error("Push level stayed valid after a push flush");
    a_pop_inval: assert property (take_q |=> !pop_level_ok)
        else $error("Pop level stayed valid after a pop flush");
    a_push_clear: assert property (s_push_last |=> s_emptied)
        else $error("Levels not emptied on second pop tick");
    a_pop_clear: assert property (s_pop_last |=> s_emptied)
        else $error("Levels not emptied on second push tick");
    a_push_back: assert property (pf_n == 2'd2 && push_tick && !push_level_ok |=> push_level_ok)
        else $error("Push level not valid after next push tick");
    a_pop_back: assert property (qf_n == 2'd2 && pop_tick && !pop_level_ok |=> pop_level_ok)
        else $error("Pop level not valid after next pop tick");
    a_level_hold: assert property ($changed(push_level) || $changed(pop_level)
        |-> $past(push_tick) || $past(pop_tick))
        else $error("Level code moved between ticks");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("Write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("Read answer late");
endmodule // flush_fifo_properties

bind flush_fifo flush_fifo_properties i_props (.*);
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for flush_fifo: AXI register access, streams, flushes.
// Assumes fabric_side supplies the ticks and the filtered clear.
`timescale 1ns/1ps
`default_nettype none
`include "flush_fifo_defs.vh"
module tb_top;
    localparam [31:0] ALL = 32'hFFFFFFFF;
    localparam [1:0]  OK  = `RESP_OKAY;
    logic        aclk;
    logic        aresetn = 1'b0, clr_raw = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF, push_level, pop_level;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, took = 1'b0;
    logic        push = 1'b0, push_flush = 1'b0, pop = 1'b0, pop_flush = 1'b0;
    logic [17:0] din = 18'h0, dout;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        push_tick, pop_tick, async_clr, irq;
    logic        almost_full, almost_empty, push_level_ok, pop_level_ok;
    integer      miscompares = 0, check_count = 0;
    logic [15:0] seed = 16'd39947;
    logic [33:0] rq[$];
    logic [31:0] mq[$];
    logic [17:0] dq[$];

    flush_fifo i_dut (.*);
    fabric_side i_side (.*);

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    function automatic [15:0] nx(input [15:0] x);
        nx = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic chk(input string n, input [33:0] e, input [33:0] g);
        check_count = check_count + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic idle(input integer n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic wr(input [7:0] a, input [31:0] d, input [1:0] e);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        chk("bresp", e, s_axi_bresp);
    endtask

    task automatic rd(input [7:0] a, input [31:0] e, input [31:0] m, input [1:0] r);
        rq.push_back({r, e & m});
        mq.push_back(m);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
    endtask

    task automatic fill(input integer n);
        repeat (n) begin
            seed = nx(seed);
            din <= {seed[1:0], seed};
            push <= 1'b1;
            do @(posedge aclk); while (push_tick !== 1'b1);
            dq.push_back({seed[1:0], seed});
        end
        push <= 1'b0;
    endtask

    task automatic drain(input integer n);
        pop <= 1'b1;
        repeat (n) do @(posedge aclk); while (pop_tick !== 1'b1);
        pop <= 1'b0;
    endtask

    task automatic flush(input bit s);
        if (s) pop_flush <= 1'b1;
        else push_flush <= 1'b1;
        do @(posedge aclk); while ((s ? pop_tick : push_tick) !== 1'b1);
        push_flush <= 1'b0;
        pop_flush <= 1'b0;
        dq.delete();
    endtask

    // Result watcher: read data and popped words against the oldest note
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
            chk("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata & mq.pop_front()});
        if (took) chk("dout", dq.pop_front(), dout);
        took <= pop_tick && pop && dq.size() > 0;
    end

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`REG_CTRL, 32'h0, ALL, OK);
        rd(`REG_INT_MASK, 32'h0, ALL, OK);
        rd(`REG_INT_STAT, 32'h0, ALL, OK);
        rd(`REG_STATUS, 32'h00018020, 32'hFFFFFFE3, OK);
        rd(8'h10, 32'h0, ALL, `RESP_SLVERR);
        wr(8'h10, ALL, `RESP_SLVERR);
        wr(`REG_INT_MASK, 32'hF, OK);
        fill(1);
        idle(20);
        rd(`REG_STATUS, 32'h0001C200, 32'hFFFFFE03, OK);
        fill(4);
        drain(6);
        rd(`REG_INT_STAT, 32'h8, ALL, OK);
        chk("irq", 1'b1, irq);
        wr(`REG_INT_MASK, 32'h0, OK);
        idle(2);
        chk("irq", 1'b0, irq);
        wr(`REG_INT_MASK, 32'hF, OK);
        wr(`REG_INT_STAT, 32'h8, OK);
        rd(`REG_INT_STAT, 32'h0, ALL, OK);
        for (int s = 0; s < 2; s++) begin
            fill(3);
            flush(s[0]);
            idle(40);
            rd(`REG_STATUS, 32'h00018020, 32'hFFFFBFE3, OK);
            rd(`REG_INT_STAT, 32'h1 << s, ALL, OK);
            wr(`REG_INT_STAT, 32'h1 << s, OK);
            fill(2);
            drain(2);
        end
        // Overflow with full level code
        fill(513);
        idle(10);
        rd(`REG_STATUS, 32'h0, 32'h000001E0, OK);
        flush(1'b0);
        idle(40);
        rd(`REG_INT_STAT, 32'h5, ALL, OK);
        wr(`REG_INT_STAT, 32'h5, OK);
        // Asynchronous clear and its polarity
        fill(2);
        clr_raw <= 1'b1;
        idle(8);
        wr(`REG_CTRL, 32'h1, OK);
        idle(20);
        rd(`REG_STATUS, 32'h20, 32'h1FE0, OK);
        dq.delete();
        fill(2);
        idle(20);
        rd(`REG_STATUS, 32'h400, 32'h1E00, OK);
        clr_raw <= 1'b0;
        idle(20);
        rd(`REG_STATUS, 32'h20, 32'h1FE0, OK);
        dq.delete();
        // Second reset in mid-run
        aresetn <= 1'b0;
        idle(2);
        aresetn <= 1'b1;
        rd(`REG_CTRL, 32'h0, ALL, OK);
        rd(`REG_STATUS, 32'h00018020, 32'hFFFFFFE3, OK);
        fill(1);
        drain(1);
        idle(2);
        final_report;
    end

    initial begin
        idle(20000);
        miscompares = miscompares + 1;
        final_report;
    end
endmodule // tb_top
`default_nettype wire
